//--- rtl/usb_term_ctrl.v
// Line resistor control block with an Avalon-MM register slave
//
// Contract
// RULE1: Resistor enables depend only on speed, termination, mode and both pull-down bits.
// RULE2: Each control combination forces its state's four enables, with no override.
// RULE3: The link controller programs the control fields; the block never picks a state.
// RULE4: An active pull-up enable connects the DP pull-up resistor, else it is off.
// RULE5: An active DP pull-down enable connects the DP pull-down resistor.
// RULE6: An active DM pull-down enable connects the DM pull-down resistor.
// RULE7: An active termination enable connects the high-speed terminations on both lines.
// RULE8: Speed 01b, termination 1, mode 00b, both pull-downs: pull-downs only (host suspend).
// RULE9: Speed 01b, termination 1, mode 10b, both pull-downs: pull-downs only (host resume).
// RULE10: Speed 00b, termination 0, mode 10b, both pull-downs: pull-downs and termination.
// RULE11: Speed 00b, termination 1, mode 10b, DM pull-down only: pull-up and DM pull-down.
// RULE12: Speed 01b, termination 1, mode 00b, DM pull-down only: pull-up and DM pull-down.
// RULE13: Mode 01b clears all four enables whatever else is set.
// RULE14: Else termination needs speed 00b, select 0; pull-up needs select 1 and DP bit clear.
// RULE15: Else both pull-down enables follow their control bits directly.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "usb_term_consts.vh"

module usb_term_ctrl #(
	parameter CNT_WIDTH = 16
) (
	input  wire        CLK_I,
	input  wire        RESET_I,
	input  wire [2:0]  AVS_ADDRESS_I,
	input  wire        AVS_READ_I,
	input  wire        AVS_WRITE_I,
	input  wire [31:0] AVS_WRITEDATA_I,
	input  wire [3:0]  AVS_BYTEENABLE_I,
	output wire [31:0] AVS_READDATA_O,
	output wire        AVS_WAITREQUEST_O,
	output wire        DP_PULLUP_ENABLE_O,
	output wire        DP_LINE_PULLDOWN_CTL_ENABLE_O,
	output wire        DM_LINE_PULLDOWN_CTL_ENABLE_O,
	output wire        HIGHSPEED_TERMINATION_ENABLE_O
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [`CTRL_WIDTH-1:0] ctrl_reg;
	reg  [`CTRL_WIDTH-1:0] ctrl_next;
	reg  [3:0]             enables_reg;
	reg  [3:0]             prev_enables_reg;
	reg  [2:0]             class_reg;
	reg  [CNT_WIDTH-1:0]   change_cnt_reg;
	reg  [CNT_WIDTH-1:0]   change_cnt_next;
	reg                    undef_flag_reg;
	reg                    change_flag_reg;
	reg                    waitrequest_reg;
	reg  [31:0]            readdata_reg;
	reg  [31:0]            readdata_next;
	wire                   bus_req;
	wire                   bus_take;
	wire                   wr_take;
	wire                   rd_take;
	wire                   low_lane;
	wire [`CTRL_WIDTH-1:0] wr_bits;
	wire                   dec_pullup;
	wire                   dec_dp_pd;
	wire                   dec_dm_pd;
	wire                   dec_hsterm;
	wire [2:0]             dec_class;
	wire                   dec_undef;
	wire [3:0]             dec_enables;
	wire                   enables_change;
	wire                   flag_clear_undef;
	wire                   flag_clear_change;

	// ****************************************************************
	// Bus handshake
	// ****************************************************************
	// One wait state: the request is taken while waitrequest is still
	// high, then waitrequest drops for exactly one cycle to answer it.
	assign bus_req  = AVS_READ_I || AVS_WRITE_I;
	assign bus_take = bus_req && waitrequest_reg;
	assign wr_take  = bus_take && AVS_WRITE_I;
	assign rd_take  = bus_take && AVS_READ_I && !AVS_WRITE_I;
	assign low_lane = AVS_BYTEENABLE_I[0];
	assign wr_bits  = AVS_WRITEDATA_I[`CTRL_WIDTH-1:0];

	// Waitrequest sits high when idle and after each answer
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			waitrequest_reg <= 1'b1;
		end else begin
			waitrequest_reg <= !bus_take;
		end
	end

	// ****************************************************************
	// Control register with write, set and clear views
	// ****************************************************************
	// Only the link controller chooses the signalling state here
	always @* begin
		ctrl_next = ctrl_reg;
		if (wr_take && low_lane) begin
			if (AVS_ADDRESS_I == `REG_CTRL) begin
				ctrl_next = wr_bits; // [RULE3]
			end else if (AVS_ADDRESS_I == `REG_CTRL_SET) begin
				ctrl_next = ctrl_reg | wr_bits;
			end else if (AVS_ADDRESS_I == `REG_CTRL_CLR) begin
				ctrl_next = ctrl_reg & ~wr_bits;
			end
		end
	end

	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ctrl_reg <= `CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ****************************************************************
	// Resistor decode
	// ****************************************************************
	// Fed by the control fields alone, no other source reaches it
	resistor_decode u_decode (
		.transceiver_speed_select     (ctrl_reg[`CTRL_XCVR_MSB:`CTRL_XCVR_LSB]), // [RULE1]
		.termination_select           (ctrl_reg[`CTRL_TERM_BIT]),
		.operating_mode_field         (ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB]),
		.dp_line_pulldown_ctl         (ctrl_reg[`CTRL_DPPD_BIT]),
		.dm_line_pulldown_ctl         (ctrl_reg[`CTRL_DMPD_BIT]),
		.dp_pullup_enable             (dec_pullup),
		.dp_line_pulldown_ctl_enable           (dec_dp_pd),
		.dm_line_pulldown_ctl_enable           (dec_dm_pd),
		.highspeed_termination_enable (dec_hsterm),
		.signalling_class             (dec_class),
		.undefined_combo              (dec_undef)
	);

	// Bit order: 0 pull-up, 1 DP pull-down, 2 DM pull-down, 3 termination
	assign dec_enables    = {dec_hsterm, dec_dm_pd, dec_dp_pd, dec_pullup};
	assign enables_change = (dec_enables != enables_reg);

	// ****************************************************************
	// Registered resistor enables
	// ****************************************************************
	// Reset value matches the power-up control setting
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			enables_reg      <= 4'h6;
			prev_enables_reg <= 4'h6;
			class_reg        <= `CLASS_POWERUP;
		end else begin
			enables_reg <= dec_enables; // [RULE2]
			class_reg   <= dec_class;
			if (enables_change) begin
				prev_enables_reg <= enables_reg;
			end
		end
	end

	// Pins come straight from the enable flops
	assign DP_PULLUP_ENABLE_O             = enables_reg[0]; // [RULE4]
	assign DP_LINE_PULLDOWN_CTL_ENABLE_O           = enables_reg[1]; // [RULE5]
	assign DM_LINE_PULLDOWN_CTL_ENABLE_O           = enables_reg[2]; // [RULE6]
	assign HIGHSPEED_TERMINATION_ENABLE_O = enables_reg[3]; // [RULE7]

	// ****************************************************************
	// Change counter and sticky flags
	// ****************************************************************
	// Any write to the counter word clears it; a change in the same
	// cycle still counts as one so no event is lost
	always @* begin
		change_cnt_next = change_cnt_reg;
		if (wr_take && AVS_ADDRESS_I == `REG_CHANGE_CNT) begin
			change_cnt_next = {CNT_WIDTH{1'b0}};
		end
		if (enables_change) begin
			change_cnt_next = change_cnt_next + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Write one to clear; hardware set wins over the clear
	assign flag_clear_undef  = wr_take && low_lane && AVS_ADDRESS_I == `REG_FLAGS &&
		AVS_WRITEDATA_I[`FLAG_UNDEF_BIT];
	assign flag_clear_change = wr_take && low_lane && AVS_ADDRESS_I == `REG_FLAGS &&
		AVS_WRITEDATA_I[`FLAG_CHANGE_BIT];

	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			change_cnt_reg  <= {CNT_WIDTH{1'b0}};
			undef_flag_reg  <= 1'b0;
			change_flag_reg <= 1'b0;
		end else begin
			change_cnt_reg <= change_cnt_next;
			if (dec_undef) begin
				undef_flag_reg <= 1'b1;
			end else if (flag_clear_undef) begin
				undef_flag_reg <= 1'b0;
			end
			if (enables_change) begin
				change_flag_reg <= 1'b1;
			end else if (flag_clear_change) begin
				change_flag_reg <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	// Unmapped words read as zero and ignore writes
	always @* begin
		readdata_next = 32'h0000_0000;
		if (AVS_ADDRESS_I == `REG_CTRL || AVS_ADDRESS_I == `REG_CTRL_SET ||
			AVS_ADDRESS_I == `REG_CTRL_CLR) begin
			readdata_next[`CTRL_WIDTH-1:0] = ctrl_reg;
		end else if (AVS_ADDRESS_I == `REG_STATUS) begin
			readdata_next[`STAT_EN_MSB:`STAT_EN_LSB]       = enables_reg;
			readdata_next[`STAT_CLASS_MSB:`STAT_CLASS_LSB] = class_reg;
		end else if (AVS_ADDRESS_I == `REG_CHANGE_CNT) begin
			readdata_next[CNT_WIDTH-1:0] = change_cnt_reg;
		end else if (AVS_ADDRESS_I == `REG_PREV_STATUS) begin
			readdata_next[`STAT_EN_MSB:`STAT_EN_LSB] = prev_enables_reg;
		end else if (AVS_ADDRESS_I == `REG_FLAGS) begin
			readdata_next[`FLAG_UNDEF_BIT]  = undef_flag_reg;
			readdata_next[`FLAG_CHANGE_BIT] = change_flag_reg;
		end
	end

	// Read data is captured with the request and held until the next one
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			readdata_reg <= 32'h0000_0000;
		end else if (rd_take) begin
			readdata_reg <= readdata_next;
		end
	end

	assign AVS_READDATA_O    = readdata_reg;
	assign AVS_WAITREQUEST_O = waitrequest_reg;

endmodule
`default_nettype wire

//--- shared/usb_term_consts.vh
// Constants for the line resistor decode block and its register file
`ifndef USB_TERM_CONSTS_VH
`define USB_TERM_CONSTS_VH

// ********************************************************************
// Register word indices (byte address is four times the index)
// ********************************************************************
`define REG_CTRL        3'h0
`define REG_CTRL_SET    3'h1
`define REG_CTRL_CLR    3'h2
`define REG_STATUS      3'h3
`define REG_CHANGE_CNT  3'h4
`define REG_PREV_STATUS 3'h5
`define REG_FLAGS       3'h6

// ********************************************************************
// Control register field positions
// ********************************************************************
`define CTRL_XCVR_LSB   0
`define CTRL_XCVR_MSB   1
`define CTRL_TERM_BIT   2
`define CTRL_MODE_LSB   3
`define CTRL_MODE_MSB   4
`define CTRL_DPPD_BIT   5
`define CTRL_DMPD_BIT   6
`define CTRL_WIDTH      7

// Power-up state: speed 01b, termination 0, mode 00b, both pull-downs set
`define CTRL_RESET      7'h61

// ********************************************************************
// Status register layout
// ********************************************************************
`define STAT_EN_LSB     0
`define STAT_EN_MSB     3
`define STAT_CLASS_LSB  4
`define STAT_CLASS_MSB  6

// ********************************************************************
// Operating mode codes and signalling classes
// ********************************************************************
`define MODE_NORMAL     2'h0
`define MODE_NODRIVE    2'h1
`define MODE_NOSTUFF    2'h2
`define MODE_RESERVED   2'h3
`define SPEED_HIGH      2'h0

`define CLASS_OTHER     3'h0
`define CLASS_TRISTATE  3'h1
`define CLASS_POWERUP   3'h2
`define CLASS_HOST      3'h3
`define CLASS_PERIPH    3'h4
`define CLASS_OTG       3'h5

// ********************************************************************
// Flag register bits
// ********************************************************************
`define FLAG_UNDEF_BIT  0
`define FLAG_CHANGE_BIT 1

`endif

//--- rtl/resistor_decode.v
// Combinational decode of transceiver control bits into resistor enables
`timescale 1ns/1ns
`default_nettype none
`include "usb_term_consts.vh"

module resistor_decode (
	input  wire [1:0] transceiver_speed_select,
	input  wire       termination_select,
	input  wire [1:0] operating_mode_field,
	input  wire       dp_line_pulldown_ctl,
	input  wire       dm_line_pulldown_ctl,
	output reg        dp_pullup_enable,
	output reg        dp_line_pulldown_ctl_enable,
	output reg        dm_line_pulldown_ctl_enable,
	output reg        highspeed_termination_enable,
	output reg  [2:0] signalling_class,
	output reg        undefined_combo
);

	// ****************************************************************
	// Resistor enables
	// ****************************************************************
	// Only the five control fields enter here, nothing can override them
	always @* begin
		if (operating_mode_field == `MODE_NODRIVE) begin
			dp_pullup_enable             = 1'b0; // [RULE13]
			dp_line_pulldown_ctl_enable           = 1'b0; // [RULE13]
			dm_line_pulldown_ctl_enable           = 1'b0; // [RULE13]
			highspeed_termination_enable = 1'b0; // [RULE13]
		end else begin
			// Terminations only in high-speed with termination select low
			highspeed_termination_enable = (transceiver_speed_select == `SPEED_HIGH) &&
				!termination_select; // [RULE14] [RULE7] [RULE10]
			// Pull-up for full-speed signalling unless DP is pulled down
			dp_pullup_enable = termination_select &&
				!dp_line_pulldown_ctl; // [RULE14] [RULE4] [RULE11] [RULE12]
			dp_line_pulldown_ctl_enable = dp_line_pulldown_ctl; // [RULE15] [RULE5] [RULE8] [RULE9]
			dm_line_pulldown_ctl_enable = dm_line_pulldown_ctl; // [RULE15] [RULE6] [RULE11] [RULE12]
		end
	end

	// ****************************************************************
	// Signalling class for status reporting
	// ****************************************************************
	always @* begin
		undefined_combo = 1'b0;
		if (operating_mode_field == `MODE_NODRIVE) begin
			signalling_class = `CLASS_TRISTATE;
		end else if (transceiver_speed_select == 2'h1 && !termination_select &&
			operating_mode_field == `MODE_NORMAL && dp_line_pulldown_ctl &&
			dm_line_pulldown_ctl) begin
			signalling_class = `CLASS_POWERUP;
		end else if (dp_line_pulldown_ctl && dm_line_pulldown_ctl) begin
			signalling_class = `CLASS_HOST;
		end else if (!dp_line_pulldown_ctl && !dm_line_pulldown_ctl) begin
			signalling_class = `CLASS_PERIPH;
		end else if (!dp_line_pulldown_ctl && dm_line_pulldown_ctl) begin
			signalling_class = `CLASS_OTG;
		end else begin
			signalling_class = `CLASS_OTHER;
			undefined_combo  = 1'b1;
		end
		// Reserved mode code is not a defined signalling state
		if (operating_mode_field == `MODE_RESERVED) begin
			signalling_class = `CLASS_OTHER;
			undefined_combo  = 1'b1;
		end
	end

endmodule
`default_nettype wire

//--- tb/usb_term_ctrl_asserts.sv
// Concurrent checks on the ports of the line resistor control block
`timescale 1ns/1ns
`default_nettype none

module usb_term_ctrl_asserts #(
	parameter CNT_WIDTH = 16
) (
	input wire logic        CLK_I,
	input wire logic        RESET_I,
	input wire logic [2:0]  AVS_ADDRESS_I,
	input wire logic        AVS_READ_I,
	input wire logic        AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0]  AVS_BYTEENABLE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic        AVS_WAITREQUEST_O,
	input wire logic        DP_PULLUP_ENABLE_O,
	input wire logic        DP_LINE_PULLDOWN_CTL_ENABLE_O,
	input wire logic        DM_LINE_PULLDOWN_CTL_ENABLE_O,
	input wire logic        HIGHSPEED_TERMINATION_ENABLE_O
);
	// ********************************************************************
	// Single clock domain, reset masks every check
	// ********************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	// Bus answer timing: one wait state, low for exactly one cycle
	answer_time_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
		|=> !AVS_WAITREQUEST_O) else $error("waitrequest did not drop one cycle after a request");
	wait_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("waitrequest stayed low longer than one cycle");
	no_spurious_a: assert property ($fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I))
		else $error("waitrequest dropped without a request");
	rdata_hold_a: assert property (!(AVS_READ_I && AVS_WAITREQUEST_O) |=> $stable(AVS_READDATA_O))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (AVS_READ_I && AVS_WAITREQUEST_O && AVS_ADDRESS_I == 3'h7
		|=> AVS_READDATA_O == 32'h0) else $error("unmapped word read nonzero");
	// Enables after reset: pull-downs on, pull-up and termination off
	reset_state_a: assert property ($fell(RESET_I) |->
		!DP_PULLUP_ENABLE_O && DP_LINE_PULLDOWN_CTL_ENABLE_O && DM_LINE_PULLDOWN_CTL_ENABLE_O &&
		!HIGHSPEED_TERMINATION_ENABLE_O) else $error("bad enables after reset");
	// Without a control write the enables never move
	hold_enables_a: assert property (!AVS_WRITE_I ##1 !AVS_WRITE_I |=>
		$stable({DP_PULLUP_ENABLE_O, DP_LINE_PULLDOWN_CTL_ENABLE_O, DM_LINE_PULLDOWN_CTL_ENABLE_O,
		HIGHSPEED_TERMINATION_ENABLE_O})) else $error("enables changed without a write");
	// Pull-up excludes the DP pull-down and the termination
	pullup_excl_a: assert property (!(DP_PULLUP_ENABLE_O && DP_LINE_PULLDOWN_CTL_ENABLE_O))
		else $error("pull-up with DP pull-down");
	term_excl_a: assert property (!(DP_PULLUP_ENABLE_O && HIGHSPEED_TERMINATION_ENABLE_O))
		else $error("pull-up with termination");
endmodule

bind usb_term_ctrl usb_term_ctrl_asserts #(.CNT_WIDTH(CNT_WIDTH)) i_usb_term_ctrl_asserts (
	.CLK_I                          (CLK_I),
	.RESET_I                        (RESET_I),
	.AVS_ADDRESS_I                  (AVS_ADDRESS_I),
	.AVS_READ_I                     (AVS_READ_I),
	.AVS_WRITE_I                    (AVS_WRITE_I),
	.AVS_WRITEDATA_I                (AVS_WRITEDATA_I),
	.AVS_BYTEENABLE_I               (AVS_BYTEENABLE_I),
	.AVS_READDATA_O                 (AVS_READDATA_O),
	.AVS_WAITREQUEST_O              (AVS_WAITREQUEST_O),
	.DP_PULLUP_ENABLE_O             (DP_PULLUP_ENABLE_O),
	.DP_LINE_PULLDOWN_CTL_ENABLE_O           (DP_LINE_PULLDOWN_CTL_ENABLE_O),
	.DM_LINE_PULLDOWN_CTL_ENABLE_O           (DM_LINE_PULLDOWN_CTL_ENABLE_O),
	.HIGHSPEED_TERMINATION_ENABLE_O (HIGHSPEED_TERMINATION_ENABLE_O)
);

`default_nettype wire

//--- tb/link_master_model.sv
// Link controller model driving the register bus of the block
`timescale 1ns/1ns
`default_nettype none

module link_master_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] readdata_i,
	input  wire logic        waitrequest_i,
	output var  logic [2:0]  address_o,
	output var  logic        read_o,
	output var  logic        write_o,
	output var  logic [31:0] writedata_o,
	output var  logic [3:0]  byteenable_o
);
	// Idle bus
	initial begin
		address_o = 3'h0;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h0;
		byteenable_o = 4'hf;
	end

	// One access: hold until waitrequest is seen low, then release
	task automatic access(input logic rd, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		address_o <= a;
		writedata_o <= d;
		read_o <= rd;
		write_o <= !rd;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		q = readdata_i;
		read_o <= 1'b0;
		write_o <= 1'b0;
		address_o <= ~a;
		writedata_o <= ~d;
		@(posedge clk_i);
	endtask

	// The link chooses every control setting itself
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] q;
		access(1'b0, a, d, q);
	endtask

	task automatic rd(input logic [2:0] a, output logic [31:0] q);
		access(1'b1, a, 32'h0, q);
	endtask

	// Byte lanes for the following accesses, changed only between transfers
	task automatic lanes(input logic [3:0] b);
		byteenable_o <= b;
	endtask
endmodule

`default_nettype wire

//--- tb/tb_top.sv
// Testbench for the line resistor control block
`timescale 1ns/1ns
`default_nettype none
`include "usb_term_consts.vh"

module tb_top;
	logic        clk;
	logic        rst;
	logic [2:0]  addr;
	logic        rd_en;
	logic        wr_en;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        waitreq;
	logic        pu, dppd, dmpd, term;
	int          err_count;
	int          total_checks;

	usb_term_ctrl i_usb_term_ctrl (.CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata),
		.AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
		.DP_PULLUP_ENABLE_O(pu), .DP_LINE_PULLDOWN_CTL_ENABLE_O(dppd), .DM_LINE_PULLDOWN_CTL_ENABLE_O(dmpd),
		.HIGHSPEED_TERMINATION_ENABLE_O(term));

	link_master_model i_link_master_model (.clk_i(clk), .readdata_i(rdata),
		.waitrequest_i(waitreq), .address_o(addr), .read_o(rd_en), .write_o(wr_en),
		.writedata_o(wdata), .byteenable_o(be));

	// ********************************************************************
	// Clock and watchdog
	// ********************************************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#20000;
		err_count++;
		conclude();
	end

	// Compare helper
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Enables as {pull-up, DP pull-down, DM pull-down, termination}
	task automatic set_and_check(input logic [6:0] c, input logic [3:0] e);
		i_link_master_model.wr(`REG_CTRL, {25'h0, c});
		cmp({28'h0, pu, dppd, dmpd, term}, {28'h0, e});
	endtask

	// Reset values of control word and enables
	task automatic t_reset;
		logic [31:0] q;
		cmp({28'h0, pu, dppd, dmpd, term}, 32'h6);
		i_link_master_model.rd(`REG_CTRL, q);
		cmp(q, 32'h61);
		$display("test reset done");
	endtask

	// Back-to-back rows of the signalling state table
	task automatic t_table;
		set_and_check(7'h65, 4'h6);
		set_and_check(7'h75, 4'h6);
		set_and_check(7'h70, 4'h7);
		set_and_check(7'h54, 4'ha);
		set_and_check(7'h45, 4'ha);
		set_and_check(7'h6c, 4'h0);
		set_and_check(7'h0b, 4'h0);
		set_and_check(7'h2e, 4'h0);
		set_and_check(7'h00, 4'h1);
		set_and_check(7'h14, 4'h8);
		set_and_check(7'h38, 4'h5);
		set_and_check(7'h1c, 4'h8);
		set_and_check(7'h66, 4'h6);
		set_and_check(7'h61, 4'h6);
		$display("test table done");
	endtask

	// Set and clear words, then the unmapped word
	task automatic t_setclr;
		logic [31:0] q;
		set_and_check(7'h45, 4'ha);
		i_link_master_model.wr(`REG_CTRL_SET, 32'h20);
		cmp({28'h0, pu, dppd, dmpd, term}, 32'h6);
		i_link_master_model.wr(`REG_CTRL_CLR, 32'h40);
		cmp({28'h0, pu, dppd, dmpd, term}, 32'h4);
		i_link_master_model.wr(3'h7, 32'h7f);
		i_link_master_model.rd(3'h7, q);
		cmp(q, 32'h0);
		i_link_master_model.rd(`REG_CTRL, q);
		cmp(q, 32'h25);
		cmp({28'h0, pu, dppd, dmpd, term}, 32'h4);
		$display("test set and clear done");
	endtask

	// Status, previous status, change counter, sticky flags and byte lanes
	task automatic t_status;
		logic [31:0] q;
		i_link_master_model.wr(`REG_CHANGE_CNT, 32'h0);
		i_link_master_model.wr(`REG_FLAGS, 32'h3);
		i_link_master_model.rd(`REG_FLAGS, q);
		cmp(q, 32'h1);
		set_and_check(7'h70, 4'h7);
		i_link_master_model.rd(`REG_STATUS, q);
		cmp(q, {25'h0, `CLASS_HOST, 4'he});
		i_link_master_model.rd(`REG_PREV_STATUS, q);
		cmp(q, 32'h2);
		i_link_master_model.lanes(4'h0);
		set_and_check(7'h54, 4'h7);
		i_link_master_model.lanes(4'hf);
		set_and_check(7'h45, 4'ha);
		i_link_master_model.rd(`REG_STATUS, q);
		cmp(q, {25'h0, `CLASS_OTG, 4'h5});
		i_link_master_model.rd(`REG_PREV_STATUS, q);
		cmp(q, 32'he);
		i_link_master_model.rd(`REG_CHANGE_CNT, q);
		cmp(q, 32'h2);
		i_link_master_model.rd(`REG_FLAGS, q);
		cmp(q, 32'h3);
		$display("test status done");
	endtask

	// Reset in mid-run brings back the power-up control word and enables
	task automatic t_rerst;
		logic [31:0] q;
		set_and_check(7'h70, 4'h7);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		cmp({28'h0, pu, dppd, dmpd, term}, 32'h6);
		i_link_master_model.rd(`REG_CTRL, q);
		cmp(q, 32'h61);
		$display("test mid-run reset done");
	endtask

	// Verdict and end of run
	task automatic conclude;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		err_count = 0;
		total_checks = 0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_table();
		t_setclr();
		t_status();
		t_rerst();
		conclude();
	end
endmodule

`default_nettype wire
